// >>> rtl/dcs_params.svh
// constants of the daisy-chain serial register access link
`ifndef DCS_PARAMS_SVH
`define DCS_PARAMS_SVH

// ****************************************
// word format
// ****************************************
`define DCS_WORD_BITS     16
`define DCS_ADDR_MSB      15
`define DCS_ADDR_LSB      9
`define DCS_ACCESS_BIT    8
`define DCS_DATA_MSB      7
`define DCS_ACCESS_READ   1'h1
`define DCS_ACCESS_WRITE  1'h0
`define DCS_NOP_WORD      16'hffff
`define DCS_DUMMY_BYTE    8'hff

// ****************************************
// timing
// ****************************************
`define DCS_CLK_NS        20
`define DCS_SCLK_HALF_NS  200
`define DCS_SCLK_HALF_CYC ((`DCS_SCLK_HALF_NS + `DCS_CLK_NS - 1) / `DCS_CLK_NS)
`define DCS_SYNC_RESET    3'h2

`endif

// >>> rtl/dcs_pkg.sv
// types of the daisy-chain serial register access link
package dcs_pkg;
   typedef logic [15:0] dcs_word_t;
   typedef logic [6:0]  dcs_addr_t;
   typedef logic [7:0]  dcs_byte_t;
   typedef enum logic [2:0] {
      DCS_IDLE,
      DCS_LOW,
      DCS_HIGH,
      DCS_TAIL,
      DCS_GAP
   } dcs_mstate_t;
endpackage

// >>> rtl/dcs_link_if.sv
// link wires between the chain master and one chained device
`timescale 1ns/1ps
`default_nettype none
interface dcs_link_if;
   logic sclk;
   logic cs_n;
   logic mosi;
   logic serial_out;
   logic serial_out_oe;
   logic miso;
   // ****************************************
   // wire level: pull-up while released
   // ****************************************
   assign miso = serial_out_oe ? serial_out : 1'h1;
   modport master (
      output sclk,
      output cs_n,
      output mosi,
      input  miso
   );
   modport device (
      input  sclk,
      input  cs_n,
      input  mosi,
      output serial_out,
      output serial_out_oe
   );
endinterface
`default_nettype wire

// >>> rtl/dcs_device.sv
// chained device end: 16-bit shift register, write latch and read return
`timescale 1ns/1ps
`default_nettype none
`include "dcs_params.svh"

module dcs_device (
   // clock and reset
   input  wire logic              core_clk,
   input  wire logic              sys_rst,
   // link
   dcs_link_if.device             link,
   // register write side
   output logic                   wr_strobe,
   output dcs_pkg::dcs_addr_t     wr_addr,
   output dcs_pkg::dcs_byte_t     wr_data,
   // register read side
   output logic                   rd_req,
   output dcs_pkg::dcs_addr_t     rd_addr,
   input  wire dcs_pkg::dcs_byte_t rd_data,
   // status
   output logic                   frame_active,
   output logic                   frame_drop
);

   // ****************************************
   // pin synchronisers
   // ****************************************
   localparam int SCLK_I = 2;
   localparam int CS_I   = 1;
   localparam int SDI_I  = 0;

   logic [2:0] pin_raw;
   logic [2:0] pin_s1;
   logic [2:0] pin_s2;
   logic [2:0] pin_s3;
   logic [2:0] pin_held;
   logic [2:0] pin_prev;

   assign pin_raw = {link.sclk, link.cs_n, link.mosi};

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_sync
         localparam logic [2:0] RST_ALL = `DCS_SYNC_RESET;
         localparam logic       RST_VAL = RST_ALL[gi];
         always_ff @(posedge core_clk or posedge sys_rst) begin
            if (sys_rst) begin
               pin_s1[gi]   <= RST_VAL;
               pin_s2[gi]   <= RST_VAL;
               pin_s3[gi]   <= RST_VAL;
               pin_held[gi] <= RST_VAL;
               pin_prev[gi] <= RST_VAL;
            end else begin
               pin_s1[gi] <= pin_raw[gi];
               pin_s2[gi] <= pin_s1[gi];
               pin_s3[gi] <= pin_s2[gi];
               if (pin_s2[gi] == pin_s3[gi]) begin
                  pin_held[gi] <= pin_s3[gi];
               end
               pin_prev[gi] <= pin_held[gi];
            end
         end
      end
   endgenerate

   // ****************************************
   // link events
   // ****************************************
   logic active;
   logic sclk_rise;
   logic sclk_fall;
   logic cs_fall;
   logic cs_rise;

   assign active    = ~pin_held[CS_I] & ~pin_prev[CS_I];
   assign sclk_rise = active & pin_held[SCLK_I] & ~pin_prev[SCLK_I];
   assign sclk_fall = active & ~pin_held[SCLK_I] & pin_prev[SCLK_I];
   assign cs_fall   = ~pin_held[CS_I] & pin_prev[CS_I];
   assign cs_rise   = pin_held[CS_I] & ~pin_prev[CS_I];

   // ****************************************
   // shift register and bit count
   // ****************************************
   dcs_pkg::dcs_word_t shift_word;
   dcs_pkg::dcs_word_t next_load;
   logic [4:0]         bit_cnt;
   logic               read_pending;
   logic               word_full;
   logic               is_read;
   logic               is_nop;

   assign next_load = {`DCS_DUMMY_BYTE, rd_data};
   assign word_full = (bit_cnt == 5'(`DCS_WORD_BITS));
   assign is_read   = (shift_word[`DCS_ACCESS_BIT] == `DCS_ACCESS_READ);
   assign is_nop    = (shift_word == `DCS_NOP_WORD);

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         shift_word <= 16'h0000;
      end else if (cs_fall && read_pending) begin
         shift_word <= next_load;
      end else if (sclk_rise) begin
         shift_word <= {shift_word[14:0], pin_held[SDI_I]};
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         bit_cnt <= 5'h00;
      end else if (cs_fall) begin
         bit_cnt <= 5'h00;
      end else if (sclk_rise && !word_full) begin
         bit_cnt <= bit_cnt + 5'h01;
      end
   end

   // ****************************************
   // interpretation at chip select rise
   // ****************************************
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         wr_strobe <= 1'h0;
         wr_addr   <= 7'h00;
         wr_data   <= 8'h00;
      end else begin
         wr_strobe <= 1'h0;
         if (cs_rise && word_full && !is_read) begin
            wr_strobe <= 1'h1;
            wr_addr   <= shift_word[`DCS_ADDR_MSB:`DCS_ADDR_LSB];
            wr_data   <= shift_word[`DCS_DATA_MSB:0];
         end
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rd_req  <= 1'h0;
         rd_addr <= 7'h00;
      end else begin
         rd_req <= 1'h0;
         if (cs_rise && word_full && is_read && !is_nop) begin
            rd_req  <= 1'h1;
            rd_addr <= shift_word[`DCS_ADDR_MSB:`DCS_ADDR_LSB];
         end
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         read_pending <= 1'h0;
      end else if (cs_rise && word_full && is_read && !is_nop) begin
         read_pending <= 1'h1;
      end else if (cs_fall) begin
         read_pending <= 1'h0;
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         frame_drop <= 1'h0;
      end else begin
         frame_drop <= cs_rise & ~word_full;
      end
   end

   // ****************************************
   // serial output
   // ****************************************
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         link.serial_out <= 1'h0;
      end else if (cs_fall) begin
         link.serial_out <= read_pending ? next_load[15] : shift_word[15];
      end else if (sclk_fall) begin
         link.serial_out <= shift_word[15];
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         link.serial_out_oe <= 1'h0;
         frame_active       <= 1'h0;
      end else begin
         link.serial_out_oe <= ~pin_held[CS_I];
         frame_active       <= ~pin_held[CS_I];
      end
   end

endmodule
`default_nettype wire

// >>> rtl/dcs_master.sv
// chain master end: makes the serial clock and runs one frame per start
`timescale 1ns/1ps
`default_nettype none
`include "dcs_params.svh"
module dcs_master #(
   parameter int DEVICES = 3
) (
   // clock and reset
   input  wire logic                         core_clk,
   input  wire logic                         sys_rst,
   // link
   dcs_link_if.master                        link,
   // user request
   input  wire logic                         start,
   input  wire logic [16*DEVICES-1:0]        tx_words,
   // user answer
   output logic                              idle,
   output logic                              done,
   output logic [16*DEVICES-1:0]             rx_words
);

   localparam int          NBITS = 16 * DEVICES;
   localparam logic [7:0]  HALF  = 8'(`DCS_SCLK_HALF_CYC);

   // ****************************************
   // return data synchroniser
   // ****************************************
   logic miso_s1;
   logic miso_s2;
   logic miso_s3;
   logic miso_held;

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         miso_s1   <= 1'h1;
         miso_s2   <= 1'h1;
         miso_s3   <= 1'h1;
         miso_held <= 1'h1;
      end else begin
         miso_s1 <= link.miso;
         miso_s2 <= miso_s1;
         miso_s3 <= miso_s2;
         if (miso_s2 == miso_s3) begin
            miso_held <= miso_s3;
         end
      end
   end

   // ****************************************
   // frame sequencer
   // ****************************************
   dcs_pkg::dcs_mstate_t state;
   logic [7:0]           tick;
   logic [15:0]          bits;
   logic [NBITS-1:0]     tx_sh;

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state     <= dcs_pkg::DCS_IDLE;
         tick      <= 8'h00;
         bits      <= 16'h0000;
         tx_sh     <= '0;
         rx_words  <= '0;
         link.sclk <= 1'h0;
         link.cs_n <= 1'h1;
         link.mosi <= 1'h0;
         idle      <= 1'h1;
         done      <= 1'h0;
      end else begin
         done <= 1'h0;
         case (state)
            dcs_pkg::DCS_IDLE: begin
               if (start) begin
                  tx_sh     <= tx_words;
                  link.mosi <= tx_words[NBITS-1];
                  link.cs_n <= 1'h0;
                  tick      <= HALF;
                  bits      <= 16'h0000;
                  idle      <= 1'h0;
                  state     <= dcs_pkg::DCS_LOW;
               end
            end
            dcs_pkg::DCS_LOW: begin
               if (tick == 8'h01) begin
                  link.sclk <= 1'h1;
                  rx_words  <= {rx_words[NBITS-2:0], miso_held};
                  bits      <= bits + 16'h0001;
                  tick      <= HALF;
                  state     <= dcs_pkg::DCS_HIGH;
               end else begin
                  tick <= tick - 8'h01;
               end
            end
            dcs_pkg::DCS_HIGH: begin
               if (tick == 8'h01) begin
                  link.sclk <= 1'h0;
                  tick      <= HALF;
                  if (bits == 16'(NBITS)) begin
                     state <= dcs_pkg::DCS_TAIL;
                  end else begin
                     tx_sh     <= {tx_sh[NBITS-2:0], 1'h0};
                     link.mosi <= tx_sh[NBITS-2];
                     state     <= dcs_pkg::DCS_LOW;
                  end
               end else begin
                  tick <= tick - 8'h01;
               end
            end
            dcs_pkg::DCS_TAIL: begin
               if (tick == 8'h01) begin
                  link.cs_n <= 1'h1;
                  tick      <= HALF;
                  state     <= dcs_pkg::DCS_GAP;
               end else begin
                  tick <= tick - 8'h01;
               end
            end
            dcs_pkg::DCS_GAP: begin
               if (tick == 8'h01) begin
                  done  <= 1'h1;
                  idle  <= 1'h1;
                  state <= dcs_pkg::DCS_IDLE;
               end else begin
                  tick <= tick - 8'h01;
               end
            end
            default: begin
               state <= dcs_pkg::DCS_IDLE;
            end
         endcase
      end
   end

endmodule
`default_nettype wire

// >>> tb/dcs_link_assertions.sv
// concurrent checks on the master to device link wires
`timescale 1ns/1ps
`default_nettype none
module dcs_link_assertions #(
   parameter int DEVICES = 3
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // link
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic mosi,
   input wire logic serial_out,
   input wire logic serial_out_oe,
   input wire logic miso
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   logic sclk_q;
   int   n_rise;
   // ****************************************
   // rises of the serial clock in a frame
   // ****************************************
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         sclk_q <= 1'h0;
         n_rise <= 0;
      end else begin
         sclk_q <= sclk;
         if (cs_n) begin
            n_rise <= 0;
         end else if (sclk && !sclk_q) begin
            n_rise <= n_rise + 1;
         end
      end
   end
   // ****************************************
   // properties
   // ****************************************
   property p_sclk_idle;
      cs_n |-> !sclk;
   endproperty
   property p_half_period;
      $rose(sclk) |-> sclk [*8] ##1 sclk [*2] ##1 !sclk;
   endproperty
   property p_mosi_stable;
      $rose(sclk) |-> $stable(mosi) ##1 $stable(mosi) [*7];
   endproperty
   property p_bit_count;
      $rose(cs_n) |-> n_rise == 16 * DEVICES;
   endproperty
   property p_oe_on;
      $fell(cs_n) |-> ##[2:8] serial_out_oe;
   endproperty
   property p_released;
      cs_n [*8] |-> !serial_out_oe && miso;
   endproperty
   property p_out_hold;
      $rose(sclk) && !cs_n |=> $stable(serial_out) [*8];
   endproperty
   property p_gap;
      $rose(cs_n) |=> cs_n [*8];
   endproperty
   a_sclk_idle: assert property (p_sclk_idle) else $error("clock high outside frame");
   a_half_period: assert property (p_half_period) else $error("clock high phase length");
   a_mosi_stable: assert property (p_mosi_stable) else $error("mosi moved near rise");
   a_bit_count: assert property (p_bit_count) else $error("bits per frame");
   a_oe_on: assert property (p_oe_on) else $error("output not driven in frame");
   a_released: assert property (p_released) else $error("output not released");
   a_out_hold: assert property (p_out_hold) else $error("output moved while clock high");
   a_gap: assert property (p_gap) else $error("frames too close");
   c_frame: cover property ($rose(cs_n));
   c_drive: cover property ($rose(serial_out_oe));
   c_low_bit: cover property (!cs_n && !miso);
endmodule
`default_nettype wire

// >>> tb/daisy_chain_spi_register_access_tb_top.sv
// testbench: master and device joined, second device driven by the bench
`timescale 1ns/1ps
`default_nettype none
module daisy_chain_spi_register_access_tb_top;
   logic               core_clk = 1'h0;
   logic               sys_rst = 1'h1;
   logic               start = 1'h0;
   dcs_pkg::dcs_word_t tx_words = 16'h0000;
   dcs_pkg::dcs_word_t rx_words, mon = 16'h0000, r;
   logic               idle, done, wr_strobe, rd_req, frame_active, frame_drop;
   logic               wr_strobe_2, rd_req_2, frame_active_2, frame_drop_2;
   dcs_pkg::dcs_addr_t wr_addr, rd_addr, wr_addr_2, rd_addr_2;
   dcs_pkg::dcs_byte_t wr_data, wr_data_2, rd_data = 8'h00;
   dcs_pkg::dcs_byte_t regs [128];
   logic [19:0]        so2 = 20'h00000;
   int                 n_errors = 0, tests_run = 0, n_wr = 0, n_rd = 0, n_wr2 = 0, n_drop2 = 0, cycles = 0;
   dcs_link_if link();
   dcs_link_if link2();
   dcs_master #(.DEVICES(1)) i_dcs_master (.core_clk(core_clk), .sys_rst(sys_rst), .link(link),
      .start(start), .tx_words(tx_words), .idle(idle), .done(done), .rx_words(rx_words));
   dcs_device i_dcs_device (.core_clk(core_clk), .sys_rst(sys_rst), .link(link), .wr_strobe(wr_strobe),
      .wr_addr(wr_addr), .wr_data(wr_data), .rd_req(rd_req), .rd_addr(rd_addr), .rd_data(rd_data),
      .frame_active(frame_active), .frame_drop(frame_drop));
   dcs_device i_dcs_device_2 (.core_clk(core_clk), .sys_rst(sys_rst), .link(link2), .wr_strobe(wr_strobe_2),
      .wr_addr(wr_addr_2), .wr_data(wr_data_2), .rd_req(rd_req_2), .rd_addr(rd_addr_2), .rd_data(8'h00),
      .frame_active(frame_active_2), .frame_drop(frame_drop_2));
   dcs_link_assertions #(.DEVICES(1)) i_dcs_link_assertions (.core_clk(core_clk), .sys_rst(sys_rst),
      .sclk(link.sclk), .cs_n(link.cs_n), .mosi(link.mosi), .serial_out(link.serial_out),
      .serial_out_oe(link.serial_out_oe), .miso(link.miso));
   always #10 core_clk = ~core_clk;
   // ****************************************
   // register file, event counts, wire monitor
   // ****************************************
   always @(posedge core_clk) begin
      if (wr_strobe === 1'h1) regs[wr_addr] <= wr_data;
      rd_data <= regs[rd_addr];
      n_wr <= n_wr + int'(wr_strobe === 1'h1);
      n_rd <= n_rd + int'(rd_req === 1'h1);
      n_wr2 <= n_wr2 + int'(wr_strobe_2 === 1'h1);
      n_drop2 <= n_drop2 + int'(frame_drop_2 === 1'h1);
      cycles <= cycles + 1;
      if (cycles == 12000) begin
         n_errors++;
         end_sim();
      end
   end
   always @(posedge link.sclk) if (link.cs_n === 1'h0) mon <= {mon[14:0], link.mosi};
   // ****************************************
   // tasks
   // ****************************************
   task automatic chk_w(input dcs_pkg::dcs_word_t got, input dcs_pkg::dcs_word_t exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_b(input dcs_pkg::dcs_byte_t got, input dcs_pkg::dcs_byte_t exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic frame(input dcs_pkg::dcs_word_t w, output dcs_pkg::dcs_word_t q);
      int i;
      tx_words <= w;
      start <= 1'h1;
      @(posedge core_clk);
      start <= 1'h0;
      for (i = 0; i < 2000 && done !== 1'h1; i++) @(posedge core_clk);
      q = rx_words;
      chk_w(mon, w);
      chk_b({5'h00, done, idle, frame_active}, 8'h06);
   endtask
   task automatic bb(input int n, input logic [19:0] bits, input logic hold_cs);
      int i;
      link2.cs_n <= hold_cs;
      repeat (8) @(posedge core_clk);
      for (i = n - 1; i >= 0; i--) begin
         link2.mosi <= bits[i];
         repeat (4) @(posedge core_clk);
         link2.sclk <= 1'h1;
         repeat (4) @(posedge core_clk);
         so2 = {so2[18:0], link2.serial_out};
         link2.sclk <= 1'h0;
      end
      repeat (8) @(posedge core_clk);
      link2.cs_n <= 1'h1;
      link2.mosi <= ~bits[0];
      repeat (16) @(posedge core_clk);
   endtask
   task automatic end_sim;
      $display("errors %0d comparisons %0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      foreach (regs[i]) regs[i] = 8'h00;
      link2.sclk = 1'h0;
      link2.cs_n = 1'h1;
      link2.mosi = 1'h0;
      repeat (3) @(posedge core_clk);
      sys_rst <= 1'h0;
      @(posedge core_clk);
      frame({7'h12, 1'h0, 8'ha5}, r);
      chk_b({1'h0, wr_addr}, 8'h12);
      chk_b(wr_data, 8'ha5);
      chk_b(8'(n_wr), 8'h01);
      frame({7'h12, 1'h1, 8'hff}, r);
      chk_w(r, {7'h12, 1'h0, 8'ha5});
      chk_b(8'(n_rd), 8'h01);
      chk_b({1'h0, rd_addr}, 8'h12);
      frame({7'h20, 1'h0, 8'h3c}, r);
      chk_w(r, 16'hffa5);
      chk_b(8'(n_wr), 8'h02);
      chk_b(regs[7'h20], 8'h3c);
      frame({7'h20, 1'h1, 8'hff}, r);
      frame(16'hffff, r);
      chk_w(r, 16'hff3c);
      chk_b(8'(n_rd), 8'h02);
      chk_b(8'(n_wr), 8'h02);
      bb(16, {4'h0, 7'h05, 1'h0, 8'h77}, 1'h1);
      chk_b(8'(n_wr2 + n_drop2), 8'h00);
      bb(8, 20'h000ff, 1'h0);
      chk_b(8'(n_drop2), 8'h01);
      chk_b(8'(n_wr2), 8'h00);
      chk_b(so2[7:0], 8'h00);
      bb(20, {4'hf, 7'h05, 1'h0, 8'h77}, 1'h0);
      chk_b(8'(n_wr2), 8'h01);
      chk_b({1'h0, wr_addr_2}, 8'h05);
      chk_b(wr_data_2, 8'h77);
      chk_w(so2[19:4], 16'h00ff);
      chk_b({4'h0, so2[3:0]}, 8'h0f);
      end_sim();
   end
endmodule
`default_nettype wire
